// >>> inc/tpo_pkg.sv
// constants and types of the heater output block
// Functional notes
// R1: heater drive is fully on or fully off only.
// R2: heater switches on and off once per cycle period, in seconds.
// R3: on-time per period equals required percentage times period length.
// R4: 100% at or below setpoint minus band, linear to 0% at setpoint.
// R5: heat status led follows the heater drive output.
// R6: integral and derivative shift the band, not its mapping.
// R7: periodic correction from setpoint minus temperature, interval set.
// R8: no integral update while temperature is outside the band.
// R9: derivative acts on temperature rate of change; removable by config.
// R10: tuning starts on setup exit if heater on, else at heater on.
// R11: auto shown while tuning runs without alarm.
// R12: tuning writes band, integral, derivative, saves them, resumes.
// R13: tuning may last ninety minutes before it is given up.
// R14: heater key toggle or tune disable aborts, old values kept.
// R15: band, integral, derivative stay writable by hand.
// R16: fixed factory code grants setup access over any user code.
// R17: zero integral or derivative setting disables that term.
// R18: cycle period accepts whole seconds in its range only.
// R19: duty latched at period start: one on then one off interval.
`default_nettype none
package tpo_pkg;
    localparam logic [7:0] ADDR_SETPOINT = 8'h00;
    localparam logic [7:0] ADDR_BAND = 8'h04;
    localparam logic [7:0] ADDR_INTEGRAL = 8'h08;
    localparam logic [7:0] ADDR_DERIV = 8'h0c;
    localparam logic [7:0] ADDR_CYCLE = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam logic [7:0] ADDR_USER_CODE = 8'h18;
    localparam logic [7:0] ADDR_CODE_ENTRY = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam int CTRL_TUNE_EN_BIT = 0;
    localparam int CTRL_SETUP_EXIT_BIT = 1;
    localparam int ST_DRIVE_BIT = 0;
    localparam int ST_HEATER_ON_BIT = 1;
    localparam int ST_TUNING_BIT = 2;
    localparam int ST_UNLOCKED_BIT = 3;
    localparam int ST_ALARM_BIT = 4;
    localparam int ST_DUTY_LSB = 8;
    localparam logic [10:0] SETPOINT_RST = 11'h000;
    localparam logic [7:0] BAND_RST = 8'h0a;
    localparam logic [7:0] INTERVAL_RST = 8'h00;
    localparam logic [4:0] CYCLE_RST = 5'h02;
    localparam logic [13:0] USER_CODE_RST = 14'h0000;
    localparam logic [7:0] SETTING_MIN = 8'h01;
    localparam logic [7:0] SETTING_MAX = 8'hc7;
    localparam logic [4:0] CYCLE_MIN = 5'h01;
    localparam logic [4:0] CYCLE_MAX = 5'h13;
    localparam logic [13:0] FACTORY_CODE = 14'h02ef;
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [11:0] I_LIMIT = 12'h3ff;
    localparam int CLK_NS = 50;
    localparam int TICK_US = 10000;
    localparam int TICK_CYCLES = TICK_US * 1000 / CLK_NS;
    localparam int TICKS_PER_S = 100;
    localparam int TUNE_LIMIT_MIN = 90;
    localparam int TUNE_LIMIT_S = TUNE_LIMIT_MIN * 60;
    typedef enum logic [2:0] {
        TPO_IDLE = 3'h0,
        TPO_ARMED = 3'h1,
        TPO_HEAT = 3'h3,
        TPO_COOL = 3'h2,
        TPO_RISE = 3'h6,
        TPO_CALC = 3'h7
    } tpo_tune_t;
endpackage
`default_nettype wire

// >>> verilog/tpo_sync3.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none
module tpo_sync3 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);
    logic s1, s2, s3;

    // s1 feeds only s2; a change counts once s2 and s3 agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/tpo_div.sv
// restoring divider: 15-bit numerator by 8-bit denominator
`default_nettype none
module tpo_div (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [14:0] numer,
    input wire logic [7:0] denom,
    output logic busy,
    output logic [14:0] quot
);
    logic [3:0] cnt;
    logic [8:0] rem;
    logic [14:0] q;
    wire [8:0] trial = {rem[7:0], q[14]};
    wire fits = trial >= {1'b0, denom};
    wire [14:0] next_q = {q[13:0], fits};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            rem <= 9'h000;
            q <= 15'h0000;
            quot <= 15'h0000;
        end else if (!busy) begin
            if (start) begin
                busy <= 1'b1;
                cnt <= 4'he;
                rem <= 9'h000;
                q <= numer;
            end
        end else begin
            rem <= fits ? trial - {1'b0, denom} : trial;
            q <= next_q;
            cnt <= cnt - 4'h1;
            if (cnt == 4'h0) begin
                busy <= 1'b0;
                quot <= next_q;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/tpo_heater_ctrl.sv
// time proportioning heater controller with apb setup registers
`default_nettype none
module tpo_heater_ctrl #(
    parameter int TICK_CYCLES_P = tpo_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [10:0] process_temp,
    input wire logic heater_key,
    input wire logic alarm_pin,
    output logic heater_drive,
    output logic heat_led,
    output logic show_auto,
    output logic nv_save
);
    import tpo_pkg::*;

    // settings and state
    logic [10:0] setpoint;
    logic [7:0] proportional_band_width;
    logic [7:0] integral_interval_setting;
    logic [7:0] deriv_interval_setting;
    logic [4:0] cycle_period_setting;
    logic [13:0] user_code;
    logic [13:0] code_entry;
    logic tune_en;
    logic heater_on;
    logic key_prev;
    logic key_level;
    logic alarm_level;
    tpo_tune_t tune_state;

    function automatic logic in_range(input logic [31:0] v,
                                      input logic [7:0] hi);
        return v <= {24'h00_0000, hi};
    endfunction

    function automatic logic [7:0] fit_setting(input logic [11:0] v);
        if (v < {4'h0, SETTING_MIN}) begin
            return SETTING_MIN;
        end else if (v > {4'h0, SETTING_MAX}) begin
            return SETTING_MAX;
        end
        return v[7:0];
    endfunction

    function automatic logic [11:0] sat12(input logic signed [12:0] v);
        if (v > $signed({1'b0, I_LIMIT})) begin
            return I_LIMIT;
        end else if (v < -$signed({1'b0, I_LIMIT})) begin
            return -I_LIMIT;
        end
        return v[11:0];
    endfunction

    tpo_sync3 u_key_sync (
        .clk(pclk),
        .rst_n(presetn),
        .pin(heater_key),
        .level(key_level)
    );

    tpo_sync3 u_alarm_sync (
        .clk(pclk),
        .rst_n(presetn),
        .pin(alarm_pin),
        .level(alarm_level)
    );

    // time base: 10 ms ticks and whole seconds
    logic [17:0] tick_cnt;
    logic [6:0] cs_in_s;
    wire cs_tick = tick_cnt == 18'(TICK_CYCLES_P - 1);
    wire sec_tick = cs_tick && cs_in_s == 7'(TICKS_PER_S - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 18'h0_0000;
            cs_in_s <= 7'h00;
        end else begin
            tick_cnt <= cs_tick ? 18'h0_0000 : tick_cnt + 18'h0_0001;
            if (cs_tick) begin
                cs_in_s <= sec_tick ? 7'h00 : cs_in_s + 7'h01;
            end
        end
    end

    // access control
    wire unlocked = user_code == 14'h0000 || code_entry == user_code
        || code_entry == FACTORY_CODE; // [R16]

    // apb decode
    wire hit_sp = paddr == ADDR_SETPOINT;
    wire hit_band = paddr == ADDR_BAND;
    wire hit_int = paddr == ADDR_INTEGRAL;
    wire hit_der = paddr == ADDR_DERIV;
    wire hit_cyc = paddr == ADDR_CYCLE;
    wire hit_ctrl = paddr == ADDR_CTRL;
    wire hit_code = paddr == ADDR_USER_CODE;
    wire hit_entry = paddr == ADDR_CODE_ENTRY;
    wire hit_stat = paddr == ADDR_STATUS;
    wire setup_reg = hit_band || hit_int || hit_der || hit_cyc
        || hit_ctrl || hit_code;
    wire mapped = setup_reg || hit_sp || hit_entry || hit_stat;
    wire cyc_ok = in_range(pwdata, {3'h0, CYCLE_MAX})
        && pwdata[4:0] >= CYCLE_MIN; // [R18]
    wire val_ok = hit_cyc ? cyc_ok
        : (hit_band || hit_int || hit_der) ? in_range(pwdata, SETTING_MAX)
        : hit_sp ? pwdata[31:11] == 21'h0
        : 1'b1;
    wire bad = !mapped || (pwrite && setup_reg && !unlocked)
        || (pwrite && hit_stat) || (pwrite && !val_ok);
    wire wr_ok = psel && penable && pwrite && !bad;
    wire setup_exit = wr_ok && hit_ctrl && pwdata[CTRL_SETUP_EXIT_BIT];
    wire key_press = key_level && !key_prev;

    assign pready = 1'b1;
    assign pslverr = psel && penable && bad;

    // tuning progress
    wire tune_running = tune_state[1]; // gray: bit 1 marks running
    logic [12:0] tune_sec;
    logic [11:0] osc_sec;
    logic [10:0] temp_hi;
    logic [10:0] temp_lo;
    wire tune_abort = tune_running && (key_press || !tune_en
        || tune_sec >= 13'(TUNE_LIMIT_S)); // [R13] [R14]
    wire [11:0] swing = {1'b0, temp_hi} - {1'b0, temp_lo};

    // pid error, shifted by integral and derivative terms
    logic signed [11:0] i_acc;
    logic signed [11:0] d_term;
    logic [10:0] prev_temp;
    logic [7:0] int_sec;
    logic [7:0] der_sec;
    wire signed [11:0] raw_err = $signed({1'b0, setpoint})
        - $signed({1'b0, process_temp});
    wire signed [13:0] err = {{2{raw_err[11]}}, raw_err}
        + {{2{i_acc[11]}}, i_acc} + {{2{d_term[11]}}, d_term}; // [R6]
    wire in_band = !raw_err[11]
        && raw_err <= $signed({4'h0, proportional_band_width});
    wire err_pos = !err[13] && err != 14'sh0000;
    wire err_full = proportional_band_width == 8'h00
        || err >= $signed({6'h00, proportional_band_width});

    // band-to-duty division runs continuously; one result is ~16 cycles
    // old, negligible against a 10 ms tick
    logic div_busy;
    logic [14:0] div_q;
    tpo_div u_div (
        .clk(pclk),
        .rst_n(presetn),
        .start(!div_busy),
        .numer(15'(err[7:0]) * 15'(PCT_FULL)),
        .denom(proportional_band_width),
        .busy(div_busy),
        .quot(div_q)
    );

    wire [6:0] pid_pct = !err_pos ? 7'h00
        : err_full ? PCT_FULL : div_q[6:0]; // [R4]
    wire [6:0] duty = (tune_state == TPO_HEAT || tune_state == TPO_RISE)
        ? PCT_FULL
        : (tune_state == TPO_COOL || tune_state == TPO_CALC) ? 7'h00
        : pid_pct;

    // register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setpoint <= SETPOINT_RST;
            proportional_band_width <= BAND_RST;
            integral_interval_setting <= INTERVAL_RST;
            deriv_interval_setting <= INTERVAL_RST;
            cycle_period_setting <= CYCLE_RST;
            user_code <= USER_CODE_RST;
            code_entry <= USER_CODE_RST;
            tune_en <= 1'b0;
        end else begin
            if (wr_ok && hit_sp) begin
                setpoint <= pwdata[10:0];
            end
            if (wr_ok && hit_band) begin
                proportional_band_width <= pwdata[7:0]; // [R15]
            end
            if (wr_ok && hit_int) begin
                integral_interval_setting <= pwdata[7:0]; // [R15]
            end
            if (wr_ok && hit_der) begin
                deriv_interval_setting <= pwdata[7:0]; // [R15]
            end
            if (wr_ok && hit_cyc) begin
                cycle_period_setting <= pwdata[4:0]; // [R18]
            end
            if (wr_ok && hit_code) begin
                user_code <= pwdata[13:0];
            end
            if (wr_ok && hit_entry) begin
                code_entry <= pwdata[13:0];
            end
            if (wr_ok && hit_ctrl) begin
                tune_en <= pwdata[CTRL_TUNE_EN_BIT];
            end
            // finished tuning overrides a coincident manual write
            if (tune_state == TPO_CALC && !tune_abort) begin
                proportional_band_width <= fit_setting(swing); // [R12]
                integral_interval_setting <= fit_setting(
                    {1'b0, osc_sec[11:1]});
                deriv_interval_setting <= fit_setting(
                    {3'h0, osc_sec[11:3]});
                tune_en <= 1'b0;
            end
        end
    end

    // read data captured in setup phase, from a flop
    wire [31:0] status_word = {17'h0_0000, duty, 3'h0, alarm_level,
        unlocked, tune_running, heater_on, heater_drive};
    wire [31:0] rd_mux = hit_sp ? 32'(setpoint)
        : hit_band ? 32'(proportional_band_width)
        : hit_int ? 32'(integral_interval_setting)
        : hit_der ? 32'(deriv_interval_setting)
        : hit_cyc ? 32'(cycle_period_setting)
        : hit_ctrl ? 32'(tune_en)
        : hit_code ? 32'(user_code)
        : hit_entry ? 32'(code_entry)
        : hit_stat ? status_word
        : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    // heater on/off key toggles the heater enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_prev <= 1'b0;
            heater_on <= 1'b0;
        end else begin
            key_prev <= key_level;
            if (key_press) begin
                heater_on <= !heater_on;
            end
        end
    end

    // integral correction, frozen outside the band
    wire int_due = int_sec + 8'h01 >= integral_interval_setting;
    wire [11:0] next_i = sat12({i_acc[11], i_acc}
        + {raw_err[11], raw_err});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            i_acc <= 12'sh000;
            int_sec <= 8'h00;
        end else if (integral_interval_setting == 8'h00) begin
            i_acc <= 12'sh000; // [R17]
            int_sec <= 8'h00;
        end else if (sec_tick) begin
            int_sec <= int_due ? 8'h00 : int_sec + 8'h01; // [R7]
            if (int_due && in_band) begin
                i_acc <= next_i; // [R7] [R8]
            end
        end
    end

    // derivative: temperature drop since last sample raises the output
    wire der_due = der_sec + 8'h01 >= deriv_interval_setting;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d_term <= 12'sh000;
            der_sec <= 8'h00;
            prev_temp <= 11'h000;
        end else if (deriv_interval_setting == 8'h00) begin
            d_term <= 12'sh000; // [R9] [R17]
            der_sec <= 8'h00;
            prev_temp <= process_temp;
        end else if (sec_tick) begin
            der_sec <= der_due ? 8'h00 : der_sec + 8'h01;
            if (der_due) begin
                d_term <= $signed({1'b0, prev_temp})
                    - $signed({1'b0, process_temp}); // [R9]
                prev_temp <= process_temp;
            end
        end
    end

    // cycle period: duty and length latched at each period start
    logic [10:0] cyc_cs;
    logic [10:0] on_cs;
    logic [4:0] cur_period;
    wire [10:0] period_cs = 11'(cur_period) * 11'(TICKS_PER_S);
    wire period_end = cyc_cs == period_cs - 11'h001;
    wire [10:0] next_on = 11'(duty) * 11'(cycle_period_setting);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_cs <= 11'h000;
            on_cs <= 11'h000;
            cur_period <= CYCLE_RST;
        end else if (cs_tick) begin
            if (period_end) begin
                cyc_cs <= 11'h000; // [R2]
                cur_period <= cycle_period_setting;
                on_cs <= next_on; // [R3] [R19]
            end else begin
                cyc_cs <= cyc_cs + 11'h001;
            end
        end
    end

    // drive is a single on/off level; power comes only from on-time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            heater_drive <= 1'b0;
        end else begin
            heater_drive <= heater_on && cyc_cs < on_cs; // [R1] [R3]
        end
    end

    assign heat_led = heater_drive; // [R5]

    // self-tuning: one on/off oscillation around the setpoint
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tune_state <= TPO_IDLE;
            tune_sec <= 13'h0000;
            osc_sec <= 12'h000;
            temp_hi <= 11'h000;
            temp_lo <= 11'h000;
        end else if (tune_abort) begin
            tune_state <= TPO_IDLE; // [R14]
        end else begin
            if (sec_tick) begin
                tune_sec <= tune_sec + 13'h0001;
                if (osc_sec != 12'hfff) begin
                    osc_sec <= osc_sec + 12'h001;
                end
            end
            case (tune_state)
                TPO_IDLE: begin
                    tune_sec <= 13'h0000;
                    if (setup_exit && pwdata[CTRL_TUNE_EN_BIT]) begin
                        tune_state <= heater_on ? TPO_HEAT
                            : TPO_ARMED; // [R10]
                    end
                end
                TPO_ARMED: begin
                    tune_sec <= 13'h0000;
                    if (!tune_en) begin
                        tune_state <= TPO_IDLE; // [R14]
                    end else if (heater_on) begin
                        tune_state <= TPO_HEAT; // [R10]
                    end
                end
                TPO_HEAT: begin
                    if (process_temp >= setpoint) begin
                        tune_state <= TPO_COOL;
                        osc_sec <= 12'h000;
                        temp_hi <= process_temp;
                        temp_lo <= process_temp;
                    end
                end
                TPO_COOL: begin
                    if (process_temp > temp_hi) begin
                        temp_hi <= process_temp;
                    end
                    if (process_temp < setpoint) begin
                        tune_state <= TPO_RISE;
                        temp_lo <= process_temp;
                    end
                end
                TPO_RISE: begin
                    if (process_temp < temp_lo) begin
                        temp_lo <= process_temp;
                    end
                    if (process_temp >= setpoint) begin
                        tune_state <= TPO_CALC;
                    end
                end
                TPO_CALC: begin
                    tune_state <= TPO_IDLE; // [R12]
                end
                default: begin
                    tune_state <= TPO_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            show_auto <= 1'b0;
            nv_save <= 1'b0;
        end else begin
            show_auto <= tune_running && !alarm_level; // [R11]
            nv_save <= tune_state == TPO_CALC && !tune_abort; // [R12]
        end
    end
endmodule
`default_nettype wire

// >>> verification/tpo_properties.sv
// concurrent checks on the heater controller ports
`default_nettype none
module tpo_props import tpo_pkg::*; #(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic alarm_pin,
    input wire logic heater_drive,
    input wire logic heat_led,
    input wire logic show_auto,
    input wire logic nv_save
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic drive_q;
    int since_rise;
    wire logic wr_acc = psel && penable && pwrite;
    wire logic set_reg = paddr == ADDR_BAND || paddr == ADDR_INTEGRAL
        || paddr == ADDR_DERIV;
    // saturating count of cycles since the drive last switched on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_q <= 1'b0;
            since_rise <= 32'h3fff_ffff;
        end else begin
            drive_q <= heater_drive;
            if (heater_drive && !drive_q) begin
                since_rise <= 0;
            end else if (since_rise < 32'h3fff_ffff) begin
                since_rise <= since_rise + 1;
            end
        end
    end
    led_follow_a: assert property (heat_led == heater_drive)
        else $error("led not following drive");
    pready_high_a: assert property (psel |-> pready)
        else $error("pready low during a transfer");
    period_once_a: assert property (heater_drive && !drive_q
        |-> since_rise >= 100 * TICK_CYCLES_P - 1)
        else $error("two on intervals in a period");
    cycle_range_a: assert property (wr_acc && paddr == ADDR_CYCLE
        && (pwdata == 0 || pwdata > 32'h0000_0013) |-> pslverr)
        else $error("bad cycle period accepted");
    band_limit_a: assert property (wr_acc && set_reg
        && pwdata > 32'h0000_00c7 |-> pslverr)
        else $error("setting above limit accepted");
    unmapped_read_a: assert property (psel && penable && paddr > ADDR_STATUS
        |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    save_pulse_a: assert property (nv_save |=> !nv_save ##1 !show_auto)
        else $error("bad save pulse");
    alarm_hides_a: assert property (alarm_pin [*8] |-> !show_auto)
        else $error("auto shown during alarm");
endmodule
bind tpo_heater_ctrl tpo_props #(.TICK_CYCLES_P(TICK_CYCLES_P)) i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm_pin(alarm_pin),
    .heater_drive(heater_drive), .heat_led(heat_led),
    .show_auto(show_auto), .nv_save(nv_save));
`default_nettype wire

// >>> verification/tpo_ssr_model.sv
// solid state relay and heater load seen from the drive pin
`default_nettype none
module tpo_ssr_model (
    input wire logic pclk,
    input wire logic heater_drive,
    output int on_len = 0
);
    timeunit 1ns;
    timeprecision 1ns;
    int run = 0;
    // relay sees full load or none; on_len is the last burst
    always @(posedge pclk) begin
        if (heater_drive === 1'b1) begin
            run <= run + 1;
        end else begin
            if (run != 0) begin
                on_len <= run;
            end
            run <= 0;
        end
    end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the heater controller
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import tpo_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, heater_key = 1'b0, alarm_pin = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [10:0] process_temp = 11'h000;
    logic pready, pslverr, heater_drive, heat_led, show_auto, nv_save, err;
    int on_len, d0, fails = 0, cmp_count = 0, cycles = 0, saves = 0;
    always #25 pclk = ~pclk;
    tpo_heater_ctrl #(.TICK_CYCLES_P(10)) i_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .process_temp(process_temp),
        .heater_key(heater_key), .alarm_pin(alarm_pin),
        .heater_drive(heater_drive), .heat_led(heat_led),
        .show_auto(show_auto), .nv_save(nv_save));
    tpo_ssr_model i_ssr (.pclk(pclk), .heater_drive(heater_drive),
        .on_len(on_len));
    always @(posedge pclk) begin
        saves <= saves + int'(nv_save === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fails++;
            results();
        end
    end
    task automatic results();
        if (fails == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, logic [31:0] d, logic e);
        apb(1'b1, a, d);
        chk("write refusal", 32'(e), 32'(err));
    endtask
    task automatic rdc(input logic [7:0] a, logic [31:0] m, e);
        apb(1'b0, a, 32'h0000_0000);
        chk("read data", e, rd & m);
    endtask
    task automatic duty(input int d);
        rdc(ADDR_STATUS, 32'h0000_7f00, 32'(d) << ST_DUTY_LSB);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic press();
        heater_key <= 1'b1;
        idle(8);
        heater_key <= 1'b0;
        idle(8);
    endtask
    task automatic auto_is(input logic e);
        idle(3);
        @(negedge pclk);
        chk("show auto", 32'(e), 32'(show_auto));
        @(posedge pclk);
    endtask
    task automatic t_regs();
        rdc(ADDR_BAND, 32'h0000_00ff, 32'h0000_000a);
        rdc(ADDR_CYCLE, 32'h0000_001f, 32'h0000_0002);
        wr(ADDR_CYCLE, 32'h0000_0000, 1'b1);
        wr(ADDR_CYCLE, 32'h0000_0014, 1'b1);
        wr(ADDR_CYCLE, 32'h0000_0013, 1'b0);
        wr(ADDR_CYCLE, 32'h0000_0002, 1'b0);
        wr(ADDR_DERIV, 32'h0000_00c8, 1'b1);
        wr(ADDR_STATUS, 32'h0000_0001, 1'b1);
        rdc(8'h24, 32'hffff_ffff, 32'h0000_0000);
        wr(ADDR_USER_CODE, 32'h0000_0005, 1'b0);
        wr(ADDR_BAND, 32'h0000_0064, 1'b1);
        wr(ADDR_CODE_ENTRY, 32'h0000_02ef, 1'b0);
        wr(ADDR_BAND, 32'h0000_0064, 1'b0);
    endtask
    task automatic t_duty();
        int tt[4] = '{900, 950, 1000, 1500};
        int dd[4] = '{100, 50, 0, 0};
        wr(ADDR_SETPOINT, 32'h0000_03e8, 1'b0);
        press();
        foreach (tt[i]) begin
            process_temp <= 11'(tt[i]);
            idle(50);
            duty(dd[i]);
        end
        process_temp <= 11'h3c0;
        idle(4200);
        chk("on cycles", 32'h0000_0320, on_len);
    endtask
    task automatic t_integ();
        process_temp <= 11'h320;
        wr(ADDR_INTEGRAL, 32'h0000_0001, 1'b0);
        idle(3000);
        process_temp <= 11'h3c0;
        idle(50);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        d0 = int'(rd[14:8]);
        chk("held duty", 1, d0 == 40 || d0 == 80);
        idle(997);
        duty(d0 > 40 ? 100 : 80);
        wr(ADDR_INTEGRAL, 32'h0000_0000, 1'b0);
        idle(50);
        duty(40);
    endtask
    task automatic t_tune();
        press();
        idle(2000);
        process_temp <= 11'h384;
        wr(ADDR_CTRL, 32'h0000_0003, 1'b0);
        auto_is(1'b0);
        press();
        auto_is(1'b1);
        alarm_pin <= 1'b1;
        idle(10);
        auto_is(1'b0);
        alarm_pin <= 1'b0;
        wr(ADDR_CTRL, 32'h0000_0000, 1'b0);
        auto_is(1'b0);
        rdc(ADDR_BAND, 32'h0000_00ff, 32'h0000_0064);
        wr(ADDR_CTRL, 32'h0000_0003, 1'b0);
        idle(20);
        process_temp <= 11'h3f2;
        idle(1500);
        process_temp <= 11'h3de;
        idle(20);
        process_temp <= 11'h3e8;
        idle(20);
        chk("saves", 1, saves);
        rdc(ADDR_BAND, 32'h0000_00ff, 32'h0000_0014);
        rdc(ADDR_CTRL, 32'h0000_0003, 32'h0000_0000);
    endtask
    initial begin
        idle(4);
        presetn <= 1'b1;
        t_regs();
        t_duty();
        t_integ();
        t_tune();
        results();
    end
endmodule
`default_nettype wire
